// file: rtl/bfrp_pkg.sv
// Constants and types shared by the boot flash read-while-write protection logic
package bfrp_pkg;

	// ==================================================================
	// Register map (byte addresses on the AXI4-Lite bus)
	localparam logic [7:0] REG_CTRL_OFF   = 8'h00;  // Busy flag, op state, busy clear
	localparam logic [7:0] REG_LOCK_OFF   = 8'h04;  // Lock pairs and boot size fuses
	localparam logic [7:0] REG_EVENT_OFF  = 8'h08;  // Sticky refusal events, write one to clear
	localparam logic [7:0] REG_BSTART_OFF = 8'h0C;  // Boot section start word address

	// ==================================================================
	// Field positions
	localparam int CTRL_BUSY_BIT   = 0;  // Read-while-write region blocked
	localparam int CTRL_ACTIVE_BIT = 1;  // Programming operation running
	localparam int CTRL_STALL_BIT  = 2;  // CPU held
	localparam int CTRL_CLEAR_BIT  = 4;  // Write one to clear the busy flag
	localparam int LOCK_FUSE_LSB   = 4;  // Boot size fuses at [5:4]
	localparam int EV_STORE_BIT    = 0;  // Store-program refused
	localparam int EV_LPM_BIT      = 1;  // Program load refused
	localparam int EV_FETCH_BIT    = 2;  // Fetch from blocked region seen
	// Lock vector layout {loader_high, loader_low, app_high, app_low}
	localparam int LK_APP_LOW      = 0;
	localparam int LK_APP_HIGH     = 1;
	localparam int LK_LDR_LOW      = 2;
	localparam int LK_LDR_HIGH     = 3;

	// ==================================================================
	// Reset values and encodings
	localparam logic [3:0]  LOCK_ERASED = 4'hF;   // All pairs unprogrammed
	localparam logic [2:0]  EV_RESET    = 3'h0;
	localparam logic [1:0]  OP_ERASE    = 2'h0;   // Page erase
	localparam logic [1:0]  OP_WRITE    = 2'h1;   // Page write
	localparam logic [1:0]  OP_LOCK     = 2'h2;   // Program boot lock bits
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;

	// ==================================================================
	// Controller states
	typedef enum logic [1:0] {
		ST_IDLE,      // No programming in progress
		ST_RUN_OP,    // Target in readable region, CPU runs
		ST_HOLD_OP    // Target in stall region, CPU halted
	} bfrp_state_t;

endpackage

// file: rtl/bfrp_lock_decode.sv
// Decoder of one boot lock pair into its restrictions
`timescale 1ns/1ps
`default_nettype none

module bfrp_lock_decode (
	input  wire logic lock_high_bit,   // High bit of the pair, 0 = programmed
	input  wire logic lock_low_bit,    // Low bit of the pair, 0 = programmed
	output logic      wr_block,        // Store-program writes into the section refused
	output logic      rd_block,        // Loads from the other section refused
	output logic      int_block        // Interrupts gated while running in the section
);

	// ==================================================================
	// Pair decoding, both bits at one means no restriction
	always_comb begin
		wr_block  = ~lock_low_bit;     // see RULE12 see RULE13 see RULE16
		rd_block  = ~lock_high_bit;    // see RULE12 see RULE14 see RULE17
		int_block = ~lock_high_bit;    // see RULE15 see RULE18
	end

endmodule // bfrp_lock_decode
`default_nettype wire

// file: rtl/bfrp_protect.sv
// Access control and CPU stall logic for self-programming of the program flash
//
// How it works
// RULE1 - Programming only from boot section instructions
// RULE2 - Boot code may target any address
// RULE3 - Fuses size sections, separate lock pairs
// RULE4 - Readable-region target keeps CPU running
// RULE5 - Stall-region target halts CPU throughout
// RULE6 - Readable region never read during programming
// RULE7 - Boot section always inside stall region
// RULE8 - Busy flag shows readable region blocked
// RULE9 - Busy stays until software clears it
// RULE10 - Locks only programmed; chip erase restores
// RULE11 - General memory locks never gate self-programming
// RULE12 - One unprogrammed, zero programmed, ones unrestricted
// RULE13 - App low bit blocks app writes
// RULE14 - App high bit blocks boot loads
// RULE15 - App high bit gates app interrupts
// RULE16 - Loader low bit blocks boot writes
// RULE17 - Loader high bit blocks app loads
// RULE18 - Loader high bit gates boot interrupts
// RULE19 - Target address latched at start
// RULE20 - Refused accesses change nothing, return zero
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module bfrp_protect #(
	parameter int AW             = 12,    // Flash word address width
	parameter int HOLD_WORDS     = 1024,  // Size of the stall region at the top
	parameter int BOOT_MIN_WORDS = 128,   // Smallest boot section size
	parameter int AXI_AW         = 8      // Register bus address width
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// CPU side
	input  wire logic [AW-1:0]     pc_addr,          // Word address of the executing instruction
	input  wire logic              store_req,        // Store-program instruction, one cycle
	input  wire logic [1:0]        store_op,         // Operation code of the instruction
	input  wire logic [AW-1:0]     store_addr,       // Target word address
	input  wire logic [3:0]        store_wdata,      // Lock bits for a lock operation
	input  wire logic              lpm_req,          // Program load, one cycle
	input  wire logic [AW:0]       lpm_addr,         // Byte address of the load
	input  wire logic              int_req,          // Interrupt pending from the controller
	input  wire logic              ivec_in_boot,     // Interrupt vectors placed in boot section
	output logic                   int_allow,        // Interrupt may be taken
	output logic                   cpu_stall,        // Hold the CPU
	output logic [7:0]             lpm_rdata,        // Load result, zero when refused
	output logic                   lpm_valid,        // Load result ready, one cycle
	output logic                   lpm_denied,       // Load refused, one cycle
	output logic                   rww_busy_flag,    // Readable region blocked
	// Fuses, lock storage and external programmer
	input  wire logic [1:0]        boot_size_fuses,  // Boot size, 0 = programmed
	input  wire logic [3:0]        lock_nv,          // Stored lock bits, loaded after reset
	output logic                   lock_nv_we,       // Store lock bits, one cycle
	output logic [3:0]             lock_nv_wdata,    // Lock bits to store
	input  wire logic              prog_lock_we,     // Serial or parallel programming of locks
	input  wire logic [3:0]        prog_lock_data,   // Lock bits from the programmer
	input  wire logic              chip_erase,       // Chip erase command, one cycle
	// Flash array
	input  wire logic [7:0]        flash_rdata,      // Byte at lpm_addr, same cycle
	output logic                   flash_start,      // Start erase or write, one cycle
	output logic [1:0]             flash_op,         // Operation being run
	output logic [AW-1:0]          flash_addr,       // Latched target address
	input  wire logic              flash_done,       // Operation finished, one cycle
	// AXI4-Lite slave
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	localparam logic [AW:0] FLASH_WORDS = (AW+1)'(2**AW);  // Words in the array
	localparam logic [31:0] DATA_ZERO_W = bfrp_pkg::DATA_ZERO;  // Base of status word

	// ==================================================================
	// State record
	typedef struct packed {
		bfrp_pkg::bfrp_state_t st;        // Programming state
		logic                  busy;      // Readable region blocked
		logic [AW-1:0]         op_addr;   // Latched target
		logic [1:0]            op;        // Latched operation
		logic                  start;     // Start pulse to the array
		logic [3:0]            locks;     // Lock pairs
		logic                  ld_pend;   // Lock bits not yet loaded
		logic                  nv_we;     // Store pulse
		logic [2:0]            ev;        // Sticky events
		logic [7:0]            ldata;     // Load result
		logic                  lvalid;    // Load result pulse
		logic                  ldenied;   // Load refused pulse
		logic                  aw_got;    // Write address held
		logic [AXI_AW-1:0]     awaddr;
		logic                  w_got;     // Write data held
		logic [31:0]           wdata;
		logic [3:0]            wstrb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
	} bfrp_state_rec_t;

	bfrp_state_rec_t q;  // Registered state
	bfrp_state_rec_t d;  // Next state

	// ==================================================================
	// Section geometry
	logic [AW:0]   boot_words;   // Boot section size from fuses
	logic [AW-1:0] boot_start;   // First boot word
	logic [AW-1:0] hold_start;   // First stall-region word

	always_comb begin
		// Programmed fuses enlarge the boot section, capped to the stall region
		boot_words = (AW+1)'(BOOT_MIN_WORDS) << (~boot_size_fuses);            // see RULE3
		if (boot_words > (AW+1)'(HOLD_WORDS)) begin
			boot_words = (AW+1)'(HOLD_WORDS);                               // see RULE7
		end
		boot_start = AW'(FLASH_WORDS - boot_words);
		hold_start = AW'(FLASH_WORDS - (AW+1)'(HOLD_WORDS));
	end

	// Word lies in the boot section
	function automatic logic in_boot(input logic [AW-1:0] a);
		return a >= boot_start;
	endfunction

	// Word lies in the stall region
	function automatic logic in_hold(input logic [AW-1:0] a);
		return a >= hold_start;
	endfunction

	// Register decode: {hit, index}
	function automatic logic [2:0] reg_sel(input logic [AXI_AW-1:0] a);
		return {(a[AXI_AW-1:4] == '0), a[3:2]};
	endfunction

	// ==================================================================
	// Lock pair decoders, one per section
	logic app_wr_block, app_rd_block, app_int_block;
	logic ldr_wr_block, ldr_rd_block, ldr_int_block;

	bfrp_lock_decode u_app_lock (
		.lock_high_bit (q.locks[bfrp_pkg::LK_APP_HIGH]),
		.lock_low_bit  (q.locks[bfrp_pkg::LK_APP_LOW]),
		.wr_block      (app_wr_block),
		.rd_block      (app_rd_block),
		.int_block     (app_int_block)
	);

	bfrp_lock_decode u_ldr_lock (
		.lock_high_bit (q.locks[bfrp_pkg::LK_LDR_HIGH]),
		.lock_low_bit  (q.locks[bfrp_pkg::LK_LDR_LOW]),
		.wr_block      (ldr_wr_block),
		.rd_block      (ldr_rd_block),
		.int_block     (ldr_int_block)
	);

	// ==================================================================
	// Access decisions of this cycle
	logic          pc_boot;     // Executing from the boot section
	logic          store_tboot; // Store target in the boot section
	logic          store_block; // Store refused
	logic [AW-1:0] lpm_word;    // Load word address
	logic          lpm_held;    // Load hits blocked readable region
	logic          lpm_block;   // Load refused
	logic          sw_clear;    // Software busy clear takes effect
	logic          wr_fire;     // Register write performed
	logic          rd_fire;     // Register read taken

	always_comb begin
		pc_boot   = in_boot(pc_addr);
		store_tboot = in_boot(store_addr);
		lpm_word    = lpm_addr[AW:1];
		// Of the locks, only the boot lock pairs gate erase and write stores; no general memory lock enters here
		store_block = !pc_boot || (q.st != bfrp_pkg::ST_IDLE)                 // see RULE1 see RULE11
			|| ((store_op != bfrp_pkg::OP_LOCK) && (store_tboot ? ldr_wr_block : app_wr_block));
		lpm_held  = q.busy && !in_hold(lpm_word);                              // see RULE6
		lpm_block = lpm_held                                                    // see RULE11
			|| (pc_boot && !in_boot(lpm_word) && app_rd_block)                  // see RULE14
			|| (!pc_boot && in_boot(lpm_word) && ldr_rd_block);                 // see RULE17
		wr_fire   = q.aw_got && q.w_got && !q.bvalid;
		rd_fire   = s_axi_arvalid && !q.rvalid;
		sw_clear  = wr_fire && q.wstrb[0] && q.wdata[bfrp_pkg::CTRL_CLEAR_BIT]
			&& (reg_sel(q.awaddr) == {1'b1, bfrp_pkg::REG_CTRL_OFF[3:2]})
			&& (q.st == bfrp_pkg::ST_IDLE);                                     // see RULE9
	end

	// ==================================================================
	// Next state
	always_comb begin
		d         = q;
		d.start   = 1'b0;
		d.nv_we   = 1'b0;
		d.lvalid  = 1'b0;
		d.ldenied = 1'b0;

		// Stored lock bits arrive once after reset
		if (q.ld_pend) begin
			d.locks   = lock_nv;
			d.ld_pend = 1'b0;
		end

		// Software clear of the busy flag, only once the array is idle
		if (sw_clear) begin
			d.busy = 1'b0;                                                      // see RULE9
		end

		// Operation end releases the stall, busy stays set
		if ((q.st != bfrp_pkg::ST_IDLE) && flash_done) begin
			d.st = bfrp_pkg::ST_IDLE;                                           // see RULE5 see RULE9
		end

		// Store-program instruction
		if (store_req) begin
			if (store_block) begin
				d.ev[bfrp_pkg::EV_STORE_BIT] = 1'b1;                            // see RULE20
			end else if (store_op == bfrp_pkg::OP_LOCK) begin
				d.locks = q.locks & store_wdata;                                // see RULE10
				d.nv_we = 1'b1;
			end else begin
				d.start   = 1'b1;                                               // see RULE2
				d.op      = store_op;
				d.op_addr = store_addr;                                         // see RULE19
				d.busy    = 1'b1;                                               // see RULE8
				d.st      = in_hold(store_addr) ? bfrp_pkg::ST_HOLD_OP          // see RULE5
					: bfrp_pkg::ST_RUN_OP;                                      // see RULE4
			end
		end

		// External programmer may only program lock bits
		if (prog_lock_we) begin
			d.locks = d.locks & prog_lock_data;                                 // see RULE10
			d.nv_we = 1'b1;
		end
		// Chip erase alone returns the pairs to unprogrammed
		if (chip_erase) begin
			d.locks = bfrp_pkg::LOCK_ERASED;                                    // see RULE10
			d.nv_we = 1'b1;
		end

		// Program load
		if (lpm_req) begin
			d.lvalid = 1'b1;
			if (lpm_block) begin
				d.ldata   = 8'h00;                                              // see RULE20
				d.ldenied = 1'b1;
				d.ev[bfrp_pkg::EV_LPM_BIT] = 1'b1;
			end else begin
				d.ldata = flash_rdata;
			end
		end

		// Register bus: write channels taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (wr_fire) begin
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = reg_sel(q.awaddr)[2] ? bfrp_pkg::RESP_OKAY : bfrp_pkg::RESP_SLVERR;
			// Event register, write one to clear
			if (q.wstrb[0] && (reg_sel(q.awaddr) == {1'b1, bfrp_pkg::REG_EVENT_OFF[3:2]})) begin
				d.ev = d.ev & ~q.wdata[2:0];
			end
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end

		// Register bus: read
		if (rd_fire) begin
			d.rvalid = 1'b1;
			d.rresp  = bfrp_pkg::RESP_OKAY;
			unique case (reg_sel(s_axi_araddr))
				{1'b1, bfrp_pkg::REG_CTRL_OFF[3:2]}: begin
					d.rdata = DATA_ZERO_W | {29'h0, (q.st == bfrp_pkg::ST_HOLD_OP),
						(q.st != bfrp_pkg::ST_IDLE), q.busy};                   // see RULE8
				end
				{1'b1, bfrp_pkg::REG_LOCK_OFF[3:2]}: begin
					d.rdata = {26'h0, boot_size_fuses, q.locks};
				end
				{1'b1, bfrp_pkg::REG_EVENT_OFF[3:2]}: begin
					d.rdata = {29'h0, q.ev};
				end
				{1'b1, bfrp_pkg::REG_BSTART_OFF[3:2]}: begin
					d.rdata = 32'(boot_start);
				end
				default: begin
					// Unmapped address answers an error and zero data
					d.rdata = bfrp_pkg::DATA_ZERO;
					d.rresp = bfrp_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end

		// Fetch from the blocked region is recorded; set wins over clear
		if (q.busy && !in_hold(pc_addr)) begin
			d.ev[bfrp_pkg::EV_FETCH_BIT] = 1'b1;                                // see RULE6
		end
		if (store_req && store_block) begin
			d.ev[bfrp_pkg::EV_STORE_BIT] = 1'b1;
		end
		if (lpm_req && lpm_block) begin
			d.ev[bfrp_pkg::EV_LPM_BIT] = 1'b1;
		end
	end

	// ==================================================================
	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q         <= '0;
			q.st      <= bfrp_pkg::ST_IDLE;
			q.locks   <= bfrp_pkg::LOCK_ERASED;
			q.ld_pend <= 1'b1;
			q.ev      <= bfrp_pkg::EV_RESET;
		end else begin
			q <= d;
		end
	end

	// ==================================================================
	// Outputs
	always_comb begin
		cpu_stall     = (q.st == bfrp_pkg::ST_HOLD_OP);                        // see RULE5
		rww_busy_flag = q.busy;                                                 // see RULE8
		// Interrupt gating by the high bit of the pair of the section being executed
		int_allow     = int_req
			&& !(app_int_block && ivec_in_boot && !pc_boot)                     // see RULE15
			&& !(ldr_int_block && !ivec_in_boot && pc_boot);                    // see RULE18
		lpm_rdata     = q.ldata;
		lpm_valid     = q.lvalid;
		lpm_denied    = q.ldenied;
		lock_nv_we    = q.nv_we;
		lock_nv_wdata = q.locks;
		flash_start   = q.start;
		flash_op      = q.op;
		flash_addr    = q.op_addr;
		s_axi_awready = !q.aw_got && !q.bvalid;
		s_axi_wready  = !q.w_got && !q.bvalid;
		s_axi_bvalid  = q.bvalid;
		s_axi_bresp   = q.bresp;
		s_axi_arready = !q.rvalid;
		s_axi_rvalid  = q.rvalid;
		s_axi_rdata   = q.rdata;
		s_axi_rresp   = q.rresp;
	end

	// ==================================================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// A permitted erase or write request
	sequence s_store_ok;
		store_req && !store_block && (store_op != bfrp_pkg::OP_LOCK);
	endsequence

	// Start of an operation into the stall region
	sequence s_hold_start;
		flash_start && in_hold(flash_addr);
	endsequence

	a_store_app_none: assert property (store_req && !pc_boot |=> !flash_start)   // see RULE1
		else $error("store from application section started programming");
	a_store_any_target: assert property (s_store_ok |=> flash_start && (flash_addr == $past(store_addr))) // see RULE2
		else $error("permitted store did not start at its target");
	a_addr_latched: assert property ((q.st != bfrp_pkg::ST_IDLE) && !flash_start |-> $stable(flash_addr)) // see RULE19
		else $error("target address moved during operation");
	a_run_no_stall: assert property (flash_start && !in_hold(flash_addr) |-> !cpu_stall) // see RULE4
		else $error("cpu stalled for readable region target");
	a_hold_stall: assert property (s_hold_start |-> cpu_stall ##1 (cpu_stall || $past(flash_done))) // see RULE5
		else $error("cpu not held for stall region operation");
	a_stall_release: assert property ($fell(cpu_stall) |-> $past(flash_done))   // see RULE5
		else $error("stall ended without operation end");
	a_boot_in_hold: assert property (boot_start >= hold_start)                // see RULE7
		else $error("boot section outside stall region");
	a_busy_hold: assert property (rww_busy_flag && !sw_clear |=> rww_busy_flag) // see RULE9
		else $error("busy flag dropped without software clear");
	a_lpm_held: assert property (lpm_req && lpm_held |=> lpm_denied && (lpm_rdata == 8'h00)) // see RULE6
		else $error("load from blocked region returned data");
	a_app_wr_lock: assert property (store_req && pc_boot && !store_tboot && !q.locks[0] // see RULE13
		&& (store_op != bfrp_pkg::OP_LOCK) |=> !flash_start)
		else $error("write into locked application section");
	a_ldr_wr_lock: assert property (store_req && store_tboot && !q.locks[2] // see RULE16
		&& (store_op != bfrp_pkg::OP_LOCK) |=> !flash_start)
		else $error("write into locked boot section");
	a_lock_program: assert property (!chip_erase && !q.ld_pend |=> (q.locks & ~$past(q.locks)) == 4'h0) // see RULE10
		else $error("lock bit returned to unprogrammed");
	a_int_gate: assert property (app_int_block && ivec_in_boot && !pc_boot |-> !int_allow) // see RULE15
		else $error("interrupt taken in locked application section");

endmodule // bfrp_protect
`default_nettype wire

// file: test/bfrp_flash_model.sv
// Flash array model: answers programming starts and byte reads
`timescale 1ns/1ps
`default_nettype none
module bfrp_flash_model (
	input  wire logic        aclk,
	input  wire logic        flash_start,
	input  wire logic [7:0]  dly,          // Busy time in cycles, prompt or slow
	input  wire logic [12:0] lpm_addr,
	output logic [7:0]       flash_rdata,
	output logic             flash_done
);
	// ==================================================================
	// Array behaviour
	logic [7:0] cnt_q = 8'h00;  // Cycles left in the running operation
	// Byte pattern that depends on the address
	assign flash_rdata = lpm_addr[7:0] ^ 8'hA5;
	// Count down the operation and pulse done once
	always_ff @(posedge aclk) begin
		flash_done <= (cnt_q == 8'h01);
		cnt_q <= flash_start ? dly : (cnt_q != 8'h00) ? cnt_q - 8'h01 : cnt_q;
	end
endmodule // bfrp_flash_model
`default_nettype wire

// file: test/tb_boot_flash_rww_protection.sv
// Self-checking bench for the self-programming protection logic
`timescale 1ns/1ps
`default_nettype none
module tb_boot_flash_rww_protection;
	// ==================================================================
	// Signals
	logic aclk = 1'h0, aresetn = 1'h0, store_req = 1'h0, lpm_req = 1'h0, int_req = 1'h0, ivec_in_boot = 1'h0;
	logic prog_lock_we = 1'h0, chip_erase = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
	logic [11:0] pc_addr = '0, store_addr = '0, pc, flash_addr;
	logic [12:0] lpm_addr = '0, la;
	logic [1:0] store_op = '0, fz = 2'h3, flash_op, bresp, rresp;
	logic [3:0] store_wdata = 4'hF, lock_nv = 4'hF, prog_lock_data = 4'hF, lock_nv_wdata;
	logic [7:0] aw = '0, ar = '0, dly = 8'h03, lpm_rdata, flash_rdata;
	logic [31:0] wd = '0, rdata, v;
	logic awr, wr, bv, arr, rv, int_allow, cpu_stall, lpm_valid, lpm_denied, rww_busy_flag, lock_nv_we;
	logic flash_start, flash_done;
	int failures = 0, comparisons = 0, starts = 0, n, i;
	bfrp_protect dut_u (.aclk, .aresetn, .pc_addr, .store_req, .store_op, .store_addr, .store_wdata, .lpm_req,
		.lpm_addr, .int_req, .ivec_in_boot, .int_allow, .cpu_stall, .lpm_rdata, .lpm_valid, .lpm_denied, .rww_busy_flag,
		.boot_size_fuses(fz), .lock_nv, .lock_nv_we, .lock_nv_wdata, .prog_lock_we, .prog_lock_data, .chip_erase,
		.flash_rdata, .flash_start, .flash_op, .flash_addr, .flash_done, .s_axi_awaddr(aw), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry));
	bfrp_flash_model flash_u (.aclk, .flash_start, .dly, .lpm_addr, .flash_rdata, .flash_done);
	always #20 aclk = ~aclk;
	// Count flash starts and keep the stored lock bits
	always @(posedge aclk) begin
		if (flash_start === 1'h1) starts <= starts + 1;
		if (lock_nv_we === 1'h1) lock_nv <= lock_nv_wdata;
	end
	// ==================================================================
	// Tasks
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task results;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task tmo(input int k);
		if (k > 39) begin
			failures++;
			results;
		end
	endtask
	task axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		aw <= a; wd <= d; awv <= 1'h1; wv <= 1'h1; bry <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awr) awv <= 1'h0;
			if (wr) wv <= 1'h0;
			if (bv) break;
		end
		bry <= 1'h0;
		tmo(n);
	endtask
	task axr(input logic [7:0] a);
		@(posedge aclk);
		ar <= a; arv <= 1'h1; rry <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arr) arv <= 1'h0;
			if (rv) break;
		end
		rry <= 1'h0;
		v = rdata;
		tmo(n);
	endtask
	// Poll until no programming runs
	task settle;
		for (i = 0; i < 40; i++) begin
			axr(8'h00);
			if (v[1] === 1'h0) break;
		end
		tmo(i);
	endtask
	task store(input logic [11:0] p, input logic [1:0] op, input logic [11:0] a, input logic [3:0] d);
		@(posedge aclk);
		pc_addr <= p; store_op <= op; store_addr <= a; store_wdata <= d; store_req <= 1'h1;
		@(posedge aclk);
		store_req <= 1'h0;
		store_addr <= ~a;
		#1;
	endtask
	task lpm(input logic [11:0] p, input logic [12:0] a);
		@(posedge aclk);
		pc_addr <= p; lpm_addr <= a; lpm_req <= 1'h1;
		@(posedge aclk);
		lpm_req <= 1'h0;
		#1;
	endtask
	task irq(input logic [11:0] p, input logic vb, input logic e);
		@(posedge aclk);
		pc_addr <= p; ivec_in_boot <= vb; int_req <= 1'h1;
		#1;
		chk(int_allow, e);
	endtask
	// Expected load answer {valid, denied, data}; boot section starts at word F80
	function logic [9:0] exp_ld(input logic [11:0] p, input logic [12:0] a, input logic [3:0] lk);
		logic pb, ab, dn;
		pb = p >= 12'hF80;
		ab = a[12:1] >= 12'hF80;
		dn = (pb && !ab && !lk[1]) || (!pb && ab && !lk[3]);
		return {1'h1, dn, dn ? 8'h00 : a[7:0] ^ 8'hA5};
	endfunction
	// ==================================================================
	// Main sequence
	initial begin
		v = $urandom(32'hC1C5);
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		axr(8'h04);
		chk(v, 32'h3F);
		axr(8'h10);
		chk(rresp, bfrp_pkg::RESP_SLVERR);
		store(12'h000, 2'h0, 12'h010, 4'hF);
		chk(starts + flash_start, 0);
		store(12'hF80, 2'h1, 12'h010, 4'hF);
		chk({cpu_stall, rww_busy_flag}, 2'h1);
		chk(flash_addr, 12'h010);
		lpm(12'hF80, 13'h0020);
		chk(lpm_denied, 1'h1);
		settle;
		chk(v[0], 1'h1);
		axw(8'h00, 32'h10);
		chk(bresp, bfrp_pkg::RESP_OKAY);
		axr(8'h00);
		chk(v[0], 1'h0);
		// Refused store and load left sticky events; writing ones clears them
		axr(8'h08);
		chk(v, 32'h3);
		axw(8'h08, 32'h7);
		axr(8'h08);
		chk(v, 32'h0);
		// Slow erase of a boot page halts the CPU throughout
		dly <= 8'h14;
		store(12'hFFF, 2'h0, 12'hFC0, 4'hF);
		chk({cpu_stall, flash_op}, {1'h1, bfrp_pkg::OP_ERASE});
		repeat (10) @(posedge aclk);
		#1;
		chk(cpu_stall, 1'h1);
		settle;
		chk(cpu_stall, 1'h0);
		axw(8'h00, 32'h10);
		// Application mode 3, loader mode 4
		store(12'hF80, 2'h2, 12'h000, 4'h4);
		axr(8'h04);
		chk(v, 32'h34);
		store(12'hF80, 2'h1, 12'h020, 4'hF);
		chk(starts + flash_start, 2);
		irq(12'hF80, 1'h0, 1'h0);
		irq(12'h000, 1'h1, 1'h0);
		irq(12'h000, 1'h0, 1'h1);
		for (int k = 0; k < 24; k++) begin
			pc = {$urandom % 2 ? 5'h1F : 5'h00, 7'($urandom)};
			la = {$urandom % 2 ? 6'h3F : 6'h00, 7'($urandom)};
			lpm(pc, la);
			chk({lpm_valid, lpm_denied, lpm_rdata}, exp_ld(pc, la, 4'h4));
		end
		@(posedge aclk);
		chip_erase <= 1'h1;
		@(posedge aclk);
		chip_erase <= 1'h0;
		axr(8'h04);
		chk(v, 32'h3F);
		prog_lock_data <= 4'hB;
		prog_lock_we <= 1'h1;
		@(posedge aclk);
		prog_lock_we <= 1'h0;
		axr(8'h04);
		chk(v, 32'h3B);
		// Largest boot size, then a refused store into the locked boot section
		fz <= 2'h0;
		store(12'hF80, 2'h1, 12'hFC0, 4'hF);
		chk(starts + flash_start, 2);
		axr(8'h0C);
		chk(v, 32'hC00);
		results;
	end
endmodule // tb_boot_flash_rww_protection
`default_nettype wire
